// ==== rtl/psf_filter.sv ====
// PID position servo filter: reads the decoder count, updates the loop and
// drives the PWM compare value. Assumes a decoder counter on an 8-bit bus.
//
// Function
// (R1) P term is error times one gain.
// (R2) Integrator adds constant times error each sample.
// (R3) D term uses position minus two-back position.
// (R4) Output is P plus I minus D.
// (R5) P and I use separate datapaths.
// (R6) Coefficients stored halved, signed 16-bit fraction.
// (R7) Accumulated result doubled before use.
// (R8) Signed 16x16 fractional products, wide accumulator.
// (R9) One update per 488 us timer timeout.
// (R10) Offset added so mid duty means zero.
// (R11) PWM waveform runs without filter help.
// (R12) Count read as two bytes via select.
// (R13) Count extended to 32-bit absolute position.
// (R14) Power stage inverts PWM for other pair.
// (R15) Power stage delays enabling edges two us.
// (R16) Integrator cleared when velocity reaches threshold.
// (R17) Integrator saturates to signed 20 bits.
// (R18) Output clamped to 8-bit, minimum one short.
// (R19) Compare value held for one sample period.
// (R20) Error clamped 16-bit; old samples shift.
// (R21) Done pulse when compare value written.
`timescale 1ns/1ps
`default_nettype none
`include "psf_defines.svh"

module psf_filter #(
  parameter int SAMPLE_CYCLES = `PSF_SAMPLE_CYCLES,
  parameter int PWM_BITS = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [31:0] command_in,
  input wire logic [7:0] dec_data_in,
  output var psf_pkg::psf_dec_bus_type dec_bus_out,
  output logic [15:0] compare_out,
  output logic pwm_out,
  output logic done_out
);
  import psf_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Signed fractional 16x16 product, as a 32-bit Q31 value.
  function automatic logic signed [31:0] frac_mul(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [31:0] prod;
    prod = a * b;
    frac_mul = prod <<< 1;
  endfunction

  // --------------------------------------------------------------------
  // Sample timer and decoder input synchroniser
  // --------------------------------------------------------------------

  logic [31:0] tick_cnt; // Cycles into the present sample period.
  logic tick; // One-cycle pulse at each timeout.
  logic [7:0] data_meta; // First synchroniser stage.
  logic [7:0] data_sync; // Second synchroniser stage.

  // Periodic interval timer that starts one update per timeout.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end
    else if (tick_cnt == SAMPLE_CYCLES - 1)
    begin
      tick_cnt <= 32'h0; // R9
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // The decoder bus is asynchronous, so it passes two flops.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      data_meta <= 8'h0;
      data_sync <= 8'h0;
    end
    else
    begin
      data_meta <= dec_data_in;
      data_sync <= data_meta;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------

  psf_state_type state; // Present step of the update.
  logic [7:0] hold; // Bus settle counter for each byte read.
  logic [15:0] raw; // Assembled decoder count.
  logic [15:0] raw_prev; // Previous decoder count.
  logic [31:0] xn, xn1, xn2; // Position now, one back, two back.
  logic signed [15:0] err; // Clamped position error.
  logic signed [15:0] vel; // Velocity x(n) - x(n-2), low word.
  logic signed [31:0] integ; // Integrator state, signed 20-bit range.
  logic signed [32:0] acc; // Doubled filter sum, one guard bit against wrap.
  logic [15:0] compare; // Held compare value.

  logic signed [31:0] ediff; // Unclamped error.
  logic signed [31:0] vdiff; // Full velocity difference.
  logic signed [31:0] isum; // Integrator before limiting.
  logic [15:0] vmag; // Velocity magnitude.
  logic signed [31:0] yfull; // Result before doubling.
  logic signed [15:0] ysat; // Output after 8-bit clamp.

  // Combinational datapath for the present step.
  always_comb
  begin
    ediff = $signed(command_in - xn);
    vdiff = $signed(xn - xn2); // R3
    vmag = vel[15] ? 16'(-vel) : vel;
    isum = integ + frac_mul($signed(`PSF_COEF_A), err); // R2 R8
    yfull = integ + frac_mul($signed(`PSF_COEF_P), err) // R1 R5
          + frac_mul($signed(`PSF_COEF_B), vel); // R4 R6
    if ($signed(acc[32:16]) > $signed(`PSF_OUT_MAX)) // R18
      ysat = $signed(`PSF_OUT_MAX);
    else if ($signed(acc[32:16]) < $signed(`PSF_OUT_MIN))
      ysat = $signed(`PSF_OUT_MIN);
    else
      ysat = acc[31:16];
  end

  // Sequencer walking one full update per tick.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state <= PSF_IDLE;
      hold <= 8'h0;
      raw <= 16'h0;
      raw_prev <= 16'h0;
      xn <= 32'h0;
      xn1 <= 32'h0;
      xn2 <= 32'h0;
      err <= 16'sh0;
      vel <= 16'sh0;
      integ <= 32'sh0;
      acc <= 33'sh0;
      compare <= `PSF_PWM_OFFSET;
      done_out <= 1'b0;
      dec_bus_out <= '{cs_n: 1'b1, sel_hi: 1'b0};
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        PSF_IDLE:
        begin
          if (tick)
          begin
            state <= PSF_RDHI;
            hold <= 8'h0;
            dec_bus_out <= '{cs_n: 1'b0, sel_hi: 1'b1}; // R12
          end
        end
        PSF_RDHI:
        begin
          // Wait for the byte to settle through the synchroniser.
          if (hold == `PSF_RD_HOLD)
          begin
            raw[15:8] <= data_sync; // R12
            hold <= 8'h0;
            dec_bus_out <= '{cs_n: 1'b0, sel_hi: 1'b0};
            state <= PSF_RDLO;
          end
          else
            hold <= hold + 8'h1;
        end
        PSF_RDLO:
        begin
          if (hold == `PSF_RD_HOLD)
          begin
            raw[7:0] <= data_sync;
            dec_bus_out <= '{cs_n: 1'b1, sel_hi: 1'b0};
            state <= PSF_POS;
          end
          else
            hold <= hold + 8'h1;
        end
        PSF_POS:
        begin
          // Sign-extended delta keeps the position absolute.
          xn <= xn
                + 32'($signed(16'(raw - raw_prev))); // R13
          raw_prev <= raw;
          state <= PSF_ERR;
        end
        PSF_ERR:
        begin
          if (ediff > $signed(`PSF_ERR_MAX)) // R20
            err <= 16'sh7fff;
          else if (ediff < $signed(`PSF_ERR_MIN))
            err <= -16'sh8000;
          else
            err <= ediff[15:0];
          vel <= vdiff[15:0];
          xn2 <= xn1; // R20
          xn1 <= xn;
          state <= PSF_INT;
        end
        PSF_INT:
        begin
          if (vmag >= `PSF_VEL_LIMIT) // R16
            integ <= 32'sh0;
          else if (isum > $signed(`PSF_INT_MAX)) // R17
            integ <= $signed(`PSF_INT_MAX);
          else if (isum < $signed(`PSF_INT_MIN))
            integ <= $signed(`PSF_INT_MIN);
          else
            integ <= isum;
          state <= PSF_SUM;
        end
        PSF_SUM:
        begin
          acc <= {yfull, 1'b0}; // R7
          state <= PSF_OUT;
        end
        PSF_OUT:
        begin
          compare <= 16'(ysat + $signed(`PSF_PWM_OFFSET)); // R10 R19
          done_out <= 1'b1; // R21
          state <= PSF_IDLE;
        end
        default:
          state <= PSF_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // PWM generator
  // --------------------------------------------------------------------

  logic [PWM_BITS-1:0] pwm_cnt; // Free-running PWM period counter.

  // Runs on its own from the held compare value.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pwm_cnt <= '0;
      pwm_out <= 1'b0;
    end
    else
    begin
      pwm_cnt <= pwm_cnt + 1'b1; // R11
      pwm_out <= (16'(pwm_cnt) < compare);
    end
  end

  // Compare output comes straight from its flop.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      compare_out <= `PSF_PWM_OFFSET;
    else
      compare_out <= compare;
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------

  sequence s_out_step;
    state == PSF_OUT;
  endsequence

  a_done_timing: assert property (@(posedge mclk_in) disable iff (rst_in) // R21
    s_out_step |=> done_out) else $error("done not raised after output step");
  a_tick_period: assert property (@(posedge mclk_in) disable iff (rst_in) // R9
    tick |=> !tick) else $error("tick lasted two cycles");
  a_int_range: assert property (@(posedge mclk_in) disable iff (rst_in) // R17
    integ <= $signed(`PSF_INT_MAX) && integ >= $signed(`PSF_INT_MIN))
    else $error("integrator out of range");
  a_int_clear: assert property (@(posedge mclk_in) disable iff (rst_in) // R16
    (state == PSF_INT && vmag >= `PSF_VEL_LIMIT) |=> integ == 0)
    else $error("integrator not cleared");
  a_out_range: assert property (@(posedge mclk_in) disable iff (rst_in) // R18
    compare >= 16'h0001 && compare <= 16'h00ff) else $error("compare out of range");
  a_cmp_hold: assert property (@(posedge mclk_in) disable iff (rst_in) // R19
    !done_out |-> $stable(compare)) else $error("compare changed mid period");
  a_cmp_copy: assert property (@(posedge mclk_in) disable iff (rst_in) // R21
    done_out |=> compare_out == $past(compare)) else $error("compare not forwarded");
  a_read_select: assert property (@(posedge mclk_in) disable iff (rst_in) // R12
    (state == PSF_RDHI) |-> !dec_bus_out.cs_n) else $error("select not active");
endmodule // psf_filter

`default_nettype wire

// ==== common/psf_defines.svh ====
// Constants for the PID servo filter: coefficients, limits, timing counts.
// Assumes a 40 MHz system clock; included by the package and the design.
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH

`define PSF_CLK_MHZ 40
`define PSF_SAMPLE_US 488
`define PSF_SAMPLE_CYCLES (`PSF_SAMPLE_US * `PSF_CLK_MHZ)
`define PSF_COEF_P 16'h0a3d
`define PSF_COEF_A 16'h0028
`define PSF_COEF_B 16'hbe6d
`define PSF_VEL_LIMIT 16'h0005
`define PSF_INT_MAX 32'h0007ffff
`define PSF_INT_MIN 32'hfff80000
`define PSF_ERR_MAX 32'h00007fff
`define PSF_ERR_MIN 32'hffff8000
`define PSF_OUT_MAX 16'h007f
`define PSF_OUT_MIN 16'hff81
`define PSF_PWM_OFFSET 16'h0080
`define PSF_RD_HOLD 8'h04

`endif

// ==== common/psf_pkg.sv ====
// Types shared by the PID servo filter.
// Assumes psf_defines.svh sits on the include path.
`include "psf_defines.svh"
package psf_pkg;
  // Sequencer states, Gray coded along the update path.
  typedef enum logic [3:0] {
    PSF_IDLE = 4'h0,
    PSF_RDHI = 4'h1,
    PSF_RDLO = 4'h3,
    PSF_POS = 4'h2,
    PSF_ERR = 4'h6,
    PSF_INT = 4'h7,
    PSF_SUM = 4'h5,
    PSF_OUT = 4'h4
  } psf_state_type;

  // Bus lines toward the external decoder counter.
  typedef struct packed {
    logic cs_n;
    logic sel_hi;
  } psf_dec_bus_type;
endpackage

// ==== tb/psf_dec_model.sv ====
// Behavioural models of the far side: the decoder counter feeding the
// filter and the bridge power stage driven by its PWM output.
// Assumes the bench holds the count steady while the filter reads it.
`timescale 1ns/1ps
`default_nettype none
module psf_dec_model (
  input wire logic mclk_in,
  input wire psf_pkg::psf_dec_bus_type dec_bus_in,
  input wire logic [15:0] count_in,
  output logic [7:0] data_out
);
  import psf_pkg::*;
  logic [7:0] last = 8'h00; // Last byte shown, kept to scramble the idle bus.
  // ---------------------------------------------------------------
  // Byte lanes
  // ---------------------------------------------------------------
  // A deselected bus must not keep the old byte, so it shows the inverse.
  always_comb
  begin
    if (dec_bus_in.cs_n)
      data_out = ~last;
    else if (dec_bus_in.sel_hi)
      data_out = count_in[15:8];
    else
      data_out = count_in[7:0];
  end
  // Remember what was driven while selected.
  always_ff @(posedge mclk_in)
  begin
    if (!dec_bus_in.cs_n)
      last <= data_out;
  end
endmodule // psf_dec_model

// ---------------------------------------------------------------
// Bridge power stage
// ---------------------------------------------------------------
// Two diagonal pairs driven in opposite phase; each enabling edge is held
// back by a deadband so one leg is off before the other turns on.
module psf_bridge_model #(
  parameter int DEAD_CYCLES = 80
) (
  input wire logic mclk_in,
  input wire logic pwm_in,
  output logic pair_a_out,
  output logic pair_b_out
);
  int run_hi = 0; // Cycles the drive has stood high.
  int run_lo = 0; // Cycles the drive has stood low.
  // Count how long the drive has stood at each level.
  always_ff @(posedge mclk_in)
  begin
    run_hi <= pwm_in ? run_hi + 1 : 0;
    run_lo <= pwm_in ? 0 : run_lo + 1;
  end
  // Pair A follows the drive, pair B its inverse; each turns on late.
  always_comb
  begin
    pair_a_out = pwm_in && (run_hi >= DEAD_CYCLES);
    pair_b_out = !pwm_in && (run_lo >= DEAD_CYCLES);
  end
endmodule // psf_bridge_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the PID servo filter with a decoder model.
// Assumes psf_pkg and psf_defines.svh are compiled and on the path.
`timescale 1ns/1ps
`default_nettype none
`include "psf_defines.svh"
module testbench;
  import psf_pkg::*;
  localparam int SC = 400; // Short sample period keeps the run brief.
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] command_in = 32'h0;
  logic [15:0] enc = 16'h0; // Count held by the decoder model.
  logic [7:0] dec_data;
  psf_dec_bus_type dec_bus;
  logic [15:0] compare;
  logic pwm;
  logic done;
  logic pair_a; // Bridge pair driven by the PWM level.
  logic pair_b; // Bridge pair driven by its inverse.
  int shoot = 0; // Cycles with both pairs on.
  int gap = 0; // Dead cycles while the drive is high.
  logic [1:0] seen = 2'b00; // Each pair seen on at least once.
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int last_done = 0;
  int hi;
  logic [15:0] expq[$]; // Expected compare values, oldest first.
  logic [31:0] seed = 32'h40b6b68b;
  longint pos = 0;
  longint x1 = 0;
  longint x2 = 0;
  longint integ = 0;
  logic [15:0] prev = 16'h0;

  psf_filter #(.SAMPLE_CYCLES(SC), .PWM_BITS(8)) uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .command_in(command_in),
    .dec_data_in(dec_data), .dec_bus_out(dec_bus), .compare_out(compare),
    .pwm_out(pwm), .done_out(done));
  psf_dec_model dec (.mclk_in(mclk_in), .dec_bus_in(dec_bus), .count_in(enc),
    .data_out(dec_data));
  psf_bridge_model #(.DEAD_CYCLES(2 * `PSF_CLK_MHZ)) bridge (.mclk_in(mclk_in),
    .pwm_in(pwm), .pair_a_out(pair_a), .pair_b_out(pair_b));

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Counts mismatches and comparisons.
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Reference loop: works out the compare value for one update.
  task automatic predict(input logic [15:0] cnt, input logic [31:0] cmd);
    longint e;
    longint v;
    longint y;
    pos = pos + longint'($signed(16'(cnt - prev)));
    prev = cnt;
    e = longint'($signed(cmd)) - pos;
    e = e > 32767 ? 32767 : (e < -32768 ? -32768 : e);
    v = longint'($signed(16'(pos - x2)));
    x2 = x1;
    x1 = pos;
    if (v >= 5 || v <= -5)
      integ = 0;
    else
      integ = integ + 2 * longint'($signed(`PSF_COEF_A)) * e;
    integ = integ > 524287 ? 524287 : (integ < -524288 ? -524288 : integ);
    y = integ + 2 * longint'($signed(`PSF_COEF_P)) * e
      + 2 * longint'($signed(`PSF_COEF_B)) * v;
    y = (2 * y) >>> 16;
    y = y > 127 ? 127 : (y < -127 ? -127 : y);
    expq.push_back(16'(y + 128));
  endtask

  // Small or large moves, small or large errors, so gate and clamps both act.
  task automatic next_inputs();
    logic [15:0] cnt;
    logic [31:0] cmd;
    seed = xs(seed);
    cnt = enc + (seed[3] ? {{8{seed[15]}}, seed[15:8]} : 16'(seed[2:0]) - 16'd3);
    cmd = 32'(x1) + (seed[4] ? {{8{seed[31]}}, seed[31:8]} : 32'(seed[9:0]) - 32'd512);
    enc <= cnt;
    command_in <= cmd;
    predict(cnt, cmd);
  endtask

  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    next_inputs();
    @(negedge mclk_in);
    check16(compare, 16'h0080);
    check16({15'h0, dec_bus.cs_n}, 16'h0001);
    check16({15'h0, done}, 16'h0000);
    repeat (40)
    begin
      while (done !== 1'b1) @(negedge mclk_in);
      @(posedge mclk_in);
      next_inputs();
      @(negedge mclk_in);
    end
    repeat (SC + 300) @(posedge mclk_in);
    check16(16'(shoot), 16'h0000);
    check16({15'h0, gap > 0}, 16'h0001);
    check16({14'h0, seen}, 16'h0003);
    report_and_stop();
  end

  // Watches each update: spacing, value, then the duty of one PWM frame.
  always @(negedge mclk_in)
  begin
    if (done === 1'b1)
    begin
      if (last_done > 0)
        check16(16'(cycles - last_done), 16'(SC));
      last_done = cycles;
      @(negedge mclk_in);
      check16(compare, expq.pop_front());
      hi = 0;
      repeat (256)
      begin
        @(negedge mclk_in);
        hi += int'(pwm);
      end
      check16(16'(hi), compare);
    end
  end

  // Watches the bridge pairs for overlap and for the dead gap.
  always @(negedge mclk_in)
  begin
    if (rst_in === 1'b0)
    begin
      shoot += int'(pair_a === 1'b1 && pair_b === 1'b1);
      gap += int'(pair_a === 1'b0 && pair_b === 1'b0 && pwm === 1'b1);
      seen |= {pair_b === 1'b1, pair_a === 1'b1};
    end
  end

  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 60 * SC)
    begin
      failures++;
      report_and_stop();
    end
  end
endmodule // testbench
`default_nettype wire
